// *** src/bhw_pkg.sv ***
// shared constants, types and helpers for the branch history window slots
package bhw_pkg;
	localparam int BHW_AW = 32;
	// one fetch window is 16 bytes, so the low four address bits give the offset within the window
	localparam int BHW_WIN_BITS = 4;
	localparam int BHW_SLOTS = 3;
	localparam int BHW_SET_BITS = 4;
	localparam int BHW_SETS = 16;
	localparam int BHW_TAG_W = BHW_AW - BHW_WIN_BITS - BHW_SET_BITS;
	localparam int BHW_SET_LSB = BHW_WIN_BITS;
	localparam int BHW_TAG_LSB = BHW_WIN_BITS + BHW_SET_BITS;
	localparam logic [1:0] BHW_RR_RST = 2'h0;
	localparam logic [1:0] BHW_RR_LAST = 2'h2;

	typedef enum logic [3:0] {
		BK_JCC_REL8 = 4'h0,
		BK_JCC_REL32 = 4'h1,
		BK_JMP_REL8 = 4'h2,
		BK_JMP_REL32 = 4'h3,
		BK_JMP_REG = 4'h4,
		BK_JMP_MEM16 = 4'h5,
		BK_JMP_MEM32 = 4'h6,
		BK_CALL_REL16 = 4'h7,
		BK_CALL_RM16 = 4'h8,
		BK_CALL_REL32 = 4'h9,
		BK_CALL_RM32 = 4'ha,
		BK_RET_NEAR = 4'hb,
		BK_OTHER = 4'hf
	} bhw_kind_t;

	typedef struct packed {
		logic valid;
		logic [BHW_TAG_W-1:0] tag;
		logic [BHW_WIN_BITS-1:0] end_off;
		logic split;
		logic [BHW_AW-1:0] target;
	} bhw_entry_t;

	typedef struct packed {
		logic valid;
		logic [BHW_AW-1:0] start_addr;
		logic [BHW_AW-1:0] end_addr;
		bhw_kind_t kind;
		logic taken;
		logic [BHW_AW-1:0] target;
	} bhw_upd_t;

	typedef struct packed {
		logic hit;
		logic [BHW_AW-1:0] target;
		logic [BHW_WIN_BITS-1:0] end_off;
		logic split;
		logic alone;
	} bhw_pred_t;

	function automatic logic [BHW_SET_BITS-1:0] win_set(input logic [BHW_AW-1:0] a);
		win_set = a[BHW_TAG_LSB-1:BHW_SET_LSB];
	endfunction

	function automatic logic [BHW_TAG_W-1:0] win_tag(input logic [BHW_AW-1:0] a);
		win_tag = a[BHW_AW-1:BHW_TAG_LSB];
	endfunction

	// near branch classes that are tracked and counted against a window
	function automatic logic is_limited(input bhw_kind_t k);
		is_limited = (k != BK_OTHER) && (k <= BK_RET_NEAR);
	endfunction
endpackage

// *** src/bhw_slot_pick.sv ***
// slot choice for one window: existing match, else free slot, else victim
`timescale 1ns/10ps
module bhw_slot_pick (
	input wire logic [2:0] valid,
	input wire logic [2:0] match,
	input wire logic [1:0] rr,
	output logic hit,
	output logic free,
	output logic [1:0] slot
);
	wire [2:0] empty = ~valid;
	wire [1:0] match_idx = match[0] ? 2'h0 : (match[1] ? 2'h1 : 2'h2);
	wire [1:0] free_idx = empty[0] ? 2'h0 : (empty[1] ? 2'h1 : 2'h2);

	assign hit = |match;
	assign free = |empty;
	// a full window with no match displaces the round-robin victim
	assign slot = hit ? match_idx : (free ? free_idx : rr);
endmodule

// *** src/bhw_window_slots.sv ***
// branch history kept per aligned 16-byte fetch window, three slots each
// Functional notes
// - At most three near branches hold history in one 16-byte fetch window.
// - A branch spanning two windows belongs to the later window.
// - A taken prediction for a window-spanning branch dispatches alone.
// - Only branches that resolved taken get a slot; untaken ones use none.
// - Limit covers relative, indirect jumps, conditional jumps, near calls and near returns.
// - Excess taken branches in a window displace existing entries.
`timescale 1ns/10ps
module bhw_window_slots (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic fetch_valid,
	input wire logic [bhw_pkg::BHW_AW-1:0] fetch_addr,
	input wire bhw_pkg::bhw_upd_t upd,
	output bhw_pkg::bhw_pred_t pred
);
	import bhw_pkg::*;

	bhw_entry_t ent_r [BHW_SETS][BHW_SLOTS];
	logic [1:0] rr_r [BHW_SETS];
	bhw_pred_t pred_r;

	// update side
	// later window
	wire [BHW_SET_BITS-1:0] u_set = win_set(upd.end_addr);
	wire [BHW_TAG_W-1:0] u_tag = win_tag(upd.end_addr);
	wire [BHW_WIN_BITS-1:0] u_off = upd.end_addr[BHW_WIN_BITS-1:0];
	wire u_split = win_set(upd.start_addr) != u_set || win_tag(upd.start_addr) != u_tag;
	wire [2:0] u_valid;
	wire [2:0] u_match;
	wire u_hit;
	wire u_free;
	wire [1:0] u_slot;

	for (genvar k = 0; k < BHW_SLOTS; k++) begin : g_umatch
		assign u_valid[k] = ent_r[u_set][k].valid;
		assign u_match[k] = u_valid[k] && ent_r[u_set][k].tag == u_tag &&
			ent_r[u_set][k].end_off == u_off;
	end

	bhw_slot_pick u_pick (
		.valid(u_valid),
		.match(u_match),
		.rr(rr_r[u_set]),
		.hit(u_hit),
		.free(u_free),
		.slot(u_slot)
	);

	wire u_elig = upd.valid && is_limited(upd.kind);
	wire u_we = u_elig && upd.taken;
	wire u_repl = u_we && !u_hit && !u_free;
	wire [1:0] rr_cur = rr_r[u_set];
	wire [1:0] rr_nxt = (rr_cur == BHW_RR_LAST) ? BHW_RR_RST : 2'(rr_cur + 2'h1);

	bhw_entry_t new_ent;
	assign new_ent.valid = 1'b1;
	assign new_ent.tag = u_tag;
	assign new_ent.end_off = u_off;
	assign new_ent.split = u_split;
	assign new_ent.target = upd.target;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int s = 0; s < BHW_SETS; s++) begin
				rr_r[s] <= BHW_RR_RST;
				for (int k = 0; k < BHW_SLOTS; k++) begin
					ent_r[s][k] <= '0;
				end
			end
		end else begin
			if (u_we) begin
				ent_r[u_set][u_slot] <= new_ent;
			end
			if (u_repl) begin
				rr_r[u_set] <= rr_nxt;
			end
		end
	end

	// lookup side: nearest stored branch at or past the fetch offset
	wire [BHW_SET_BITS-1:0] f_set = win_set(fetch_addr);
	wire [BHW_TAG_W-1:0] f_tag = win_tag(fetch_addr);
	wire [BHW_WIN_BITS-1:0] f_off = fetch_addr[BHW_WIN_BITS-1:0];
	wire [2:0] f_m;
	wire [BHW_WIN_BITS-1:0] f_e [BHW_SLOTS];

	for (genvar k = 0; k < BHW_SLOTS; k++) begin : g_fmatch
		assign f_e[k] = ent_r[f_set][k].end_off;
		assign f_m[k] = ent_r[f_set][k].valid && ent_r[f_set][k].tag == f_tag &&
			f_e[k] >= f_off;
	end

	function automatic logic not_after(input logic bm, input logic [3:0] a,
			input logic [3:0] b);
		not_after = !bm || a <= b;
	endfunction

	wire sel0 = f_m[0] && not_after(f_m[1], f_e[0], f_e[1]) &&
		not_after(f_m[2], f_e[0], f_e[2]);
	wire sel1 = !sel0 && f_m[1] && not_after(f_m[2], f_e[1], f_e[2]);
	wire [1:0] f_slot = sel0 ? 2'h0 : (sel1 ? 2'h1 : 2'h2);
	wire lk_hit = fetch_valid && |f_m;
	bhw_entry_t lk_ent;
	assign lk_ent = ent_r[f_set][f_slot];

	// a split branch predicted taken cannot share its dispatch cycle,
	// so the flag travels with the prediction for the dispatch logic
	bhw_pred_t pred_nxt;
	assign pred_nxt.hit = lk_hit;
	assign pred_nxt.target = lk_hit ? lk_ent.target : '0;
	assign pred_nxt.end_off = lk_hit ? lk_ent.end_off : '0;
	assign pred_nxt.split = lk_hit && lk_ent.split;
	assign pred_nxt.alone = lk_hit && lk_ent.split;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pred_r <= '0;
		end else begin
			pred_r <= pred_nxt;
		end
	end

	assign pred = pred_r;

	// checking helpers
	wire [BHW_SETS*BHW_SLOTS-1:0] all_v;
	for (genvar s = 0; s < BHW_SETS; s++) begin : g_allv
		for (genvar k = 0; k < BHW_SLOTS; k++) begin : g_slot
			assign all_v[s*BHW_SLOTS+k] = ent_r[s][k].valid;
		end
	end

	logic [BHW_SET_BITS-1:0] chk_set_r;
	logic [BHW_TAG_W-1:0] chk_tag_r;
	logic [BHW_WIN_BITS-1:0] chk_off_r;
	logic [BHW_AW-1:0] chk_tgt_r;
	always_ff @(posedge core_clk) begin
		chk_set_r <= u_set;
		chk_tag_r <= u_tag;
		chk_off_r <= u_off;
		chk_tgt_r <= upd.target;
	end

	wire [2:0] chk_v;
	wire [2:0] chk_m;
	for (genvar k = 0; k < BHW_SLOTS; k++) begin : g_chk
		assign chk_v[k] = ent_r[chk_set_r][k].valid;
		assign chk_m[k] = chk_v[k] && ent_r[chk_set_r][k].tag == chk_tag_r &&
			ent_r[chk_set_r][k].end_off == chk_off_r &&
			ent_r[chk_set_r][k].target == chk_tgt_r;
	end
	wire chk_present = |chk_m;
	wire chk_dup = (chk_m[0] && chk_m[1]) || (chk_m[0] && chk_m[2]) ||
		(chk_m[1] && chk_m[2]);

	AST_ONE_COPY: assert property (@(posedge core_clk) disable iff (srst)
		u_we |=> chk_present && !chk_dup)
		else $error("taken branch stored zero or several times in its window");

	AST_LATER_WINDOW: assert property (@(posedge core_clk) disable iff (srst)
		u_we && u_split ##1 (fetch_valid && win_set(fetch_addr) == chk_set_r &&
			win_tag(fetch_addr) == chk_tag_r && fetch_addr[3:0] == chk_off_r)
		|=> pred.hit && pred.split)
		else $error("split branch not found in the later window");

	AST_ALONE: assert property (@(posedge core_clk) disable iff (srst)
		(lk_hit && lk_ent.split |=> pred.alone && pred.hit) and
		(!lk_hit |=> !pred.alone))
		else $error("split taken prediction not marked to dispatch alone");

	AST_NO_UNTAKEN: assert property (@(posedge core_clk) disable iff (srst)
		upd.valid && !upd.taken |=> all_v == $past(all_v))
		else $error("untaken branch changed slot occupancy");

	AST_CLASS_ONLY: assert property (@(posedge core_clk) disable iff (srst)
		upd.valid && upd.taken && !is_limited(upd.kind) |=> all_v == $past(all_v))
		else $error("untracked branch class took a slot");

	AST_DISPLACE: assert property (@(posedge core_clk) disable iff (srst)
		u_repl |=> chk_v == 3'h7 && chk_present && rr_r[chk_set_r] != $past(rr_cur))
		else $error("fourth taken branch did not displace an entry");

	AST_WINDOW_HIT: assert property (@(posedge core_clk) disable iff (srst)
		pred.hit |-> $past(fetch_valid) && pred.end_off >= $past(fetch_addr[3:0]))
		else $error("prediction without a matching fetch window");

	// victim pointer walks 0,1,2 only; a stuck 3 would point at no slot
	AST_RR_RANGE: assert property (@(posedge core_clk) disable iff (srst)
		rr_cur != 2'h3)
		else $error("round-robin victim pointer out of range");

	// dispatch sees a quiet prediction whenever fetch asked for nothing
	AST_MISS_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		!fetch_valid |=> pred == '0)
		else $error("prediction shown without a lookup");

	AST_REFRESH_KEEPS: assert property (@(posedge core_clk) disable iff (srst)
		u_we && u_hit |=> chk_v == $past(u_valid) && chk_present)
		else $error("refreshing a stored branch changed window occupancy");

	AST_ALONE_SPLIT: assert property (@(posedge core_clk) disable iff (srst)
		pred.alone |-> pred.hit && pred.split)
		else $error("dispatch-alone flag without a split taken prediction");

	COV_FILL: cover property (@(posedge core_clk) disable iff (srst)
		u_we && !u_hit && u_free && u_valid == 3'h3);
	COV_REPLACE: cover property (@(posedge core_clk) disable iff (srst) u_repl);
	COV_SPLIT_PRED: cover property (@(posedge core_clk) disable iff (srst)
		pred.alone);
	COV_REFRESH: cover property (@(posedge core_clk) disable iff (srst)
		u_we && u_hit);
	// lookup right behind the update that stored a split branch
	COV_LATE_LOOK: cover property (@(posedge core_clk) disable iff (srst)
		u_we && u_split ##1 fetch_valid);
endmodule

// *** sim/bhw_fetch_model.sv ***
// fetch side model that issues lookups and resolved branch reports
`timescale 1ns/10ps
module bhw_fetch_model (
	input wire logic core_clk,
	output logic fetch_valid,
	output logic [bhw_pkg::BHW_AW-1:0] fetch_addr,
	output bhw_pkg::bhw_upd_t upd
);
	import bhw_pkg::*;
	initial begin
		fetch_valid = 1'b0;
		fetch_addr = '0;
		upd = '0;
	end
	// released fields are inverted so no stale value looks meaningful
	task automatic report(input logic [31:0] s, input logic [31:0] e, input bhw_kind_t k,
			input logic tk, input logic [31:0] t);
		@(negedge core_clk);
		upd = '{valid: 1'b1, start_addr: s, end_addr: e, kind: k, taken: tk, target: t};
		@(posedge core_clk);
		@(negedge core_clk);
		upd = ~upd;
	endtask
	// taken report, then a lookup in the very next cycle
	task automatic report_look(input logic [31:0] s, input logic [31:0] e,
			input bhw_kind_t k, input logic [31:0] t, input logic [31:0] a);
		@(negedge core_clk);
		upd = '{valid: 1'b1, start_addr: s, end_addr: e, kind: k, taken: 1'b1, target: t};
		@(posedge core_clk);
		@(negedge core_clk);
		upd = ~upd;
		fetch_valid = 1'b1;
		fetch_addr = a;
		@(posedge core_clk);
		@(negedge core_clk);
		fetch_valid = 1'b0;
		fetch_addr = ~a;
	endtask
	task automatic look(input logic [31:0] a);
		@(negedge core_clk);
		fetch_valid = 1'b1;
		fetch_addr = a;
		@(posedge core_clk);
		@(negedge core_clk);
		fetch_valid = 1'b0;
		fetch_addr = ~a;
	endtask
endmodule

// *** sim/bhw_window_slots_tb.sv ***
// self-checking bench for the branch history window slots
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module bhw_window_slots_tb;
	import bhw_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic fetch_valid;
	logic [BHW_AW-1:0] fetch_addr;
	bhw_upd_t upd;
	bhw_pred_t pred;
	int miscompares = 0;
	int cmp_count = 0;
	bhw_window_slots dut_u (.core_clk(core_clk), .srst(srst), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .upd(upd), .pred(pred));
	bhw_fetch_model fm_u (.core_clk(core_clk), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .upd(upd));
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic do_reset;
		@(negedge core_clk);
		srst = 1'b1;
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		`CHK("pred after reset", bhw_pred_t'('0), pred)
	endtask
	// a miss must show every field at zero
	task automatic probe(input logic [31:0] a, input logic h, input logic [31:0] t,
			input logic [3:0] off, input logic sp);
		bhw_pred_t ex;
		fm_u.look(a);
		ex = h ? bhw_pred_t'{1'b1, t, off, sp, sp} : bhw_pred_t'('0);
		`CHK("pred", ex, pred)
	endtask
	task automatic s_basic;
		fm_u.report(32'h0000_1234, 32'h0000_1235, BK_JMP_REL8, 1'b1, 32'h0000_4000);
		probe(32'h0000_1230, 1'b1, 32'h0000_4000, 4'h5, 1'b0);
		probe(32'h0000_1236, 1'b0, '0, '0, 1'b0);
		probe(32'h0000_1330, 1'b0, '0, '0, 1'b0);
		fm_u.report(32'h0000_1234, 32'h0000_1235, BK_JMP_REL8, 1'b0, 32'h0000_4444);
		probe(32'h0000_1230, 1'b1, 32'h0000_4000, 4'h5, 1'b0);
	endtask
	task automatic s_untaken;
		fm_u.report(32'h0000_2004, 32'h0000_2005, BK_JCC_REL8, 1'b0, 32'h0000_4100);
		probe(32'h0000_2000, 1'b0, '0, '0, 1'b0);
		fm_u.report(32'h0000_2007, 32'h0000_2008, BK_OTHER, 1'b1, 32'h0000_4200);
		probe(32'h0000_2000, 1'b0, '0, '0, 1'b0);
		fm_u.report(32'h0000_200a, 32'h0000_200b, bhw_kind_t'(4'hc), 1'b1, 32'h0000_4300);
		probe(32'h0000_2000, 1'b0, '0, '0, 1'b0);
	endtask
	task automatic s_split;
		fm_u.report(32'h0000_301e, 32'h0000_3021, BK_JMP_REL32, 1'b1, 32'h0000_5000);
		probe(32'h0000_3010, 1'b0, '0, '0, 1'b0);
		probe(32'h0000_3020, 1'b1, 32'h0000_5000, 4'h1, 1'b1);
		fm_u.report_look(32'h0000_311f, 32'h0000_3120, BK_CALL_RM32, 32'h0000_5100,
			32'h0000_3120);
		`CHK("pred next cycle", bhw_pred_t'{1'b1, 32'h0000_5100, 4'h0, 1'b1, 1'b1}, pred)
	endtask
	task automatic s_kinds;
		logic [31:0] a;
		for (int k = 0; k < 12; k++) begin
			a = 32'h0004_0002 | (k << 4);
			fm_u.report(a, a, bhw_kind_t'(k[3:0]), 1'b1, a + 32'h100);
			probe({a[31:4], 4'h0}, 1'b1, a + 32'h100, 4'h2, 1'b0);
		end
	endtask
	// three fill the window, a fourth displaces the oldest
	task automatic s_full;
		fm_u.report(32'h0000_6002, 32'h0000_6002, BK_JCC_REL32, 1'b1, 32'h0000_7002);
		fm_u.report(32'h0000_6005, 32'h0000_6005, BK_CALL_REL32, 1'b1, 32'h0000_7005);
		fm_u.report(32'h0000_6008, 32'h0000_6008, BK_JMP_REG, 1'b1, 32'h0000_7008);
		probe(32'h0000_6000, 1'b1, 32'h0000_7002, 4'h2, 1'b0);
		probe(32'h0000_6003, 1'b1, 32'h0000_7005, 4'h5, 1'b0);
		fm_u.report(32'h0000_600c, 32'h0000_600c, BK_RET_NEAR, 1'b1, 32'h0000_700c);
		probe(32'h0000_6000, 1'b1, 32'h0000_7005, 4'h5, 1'b0);
		probe(32'h0000_6009, 1'b1, 32'h0000_700c, 4'hc, 1'b0);
		fm_u.report(32'h0000_6005, 32'h0000_6005, BK_CALL_REL32, 1'b1, 32'h0000_7777);
		probe(32'h0000_6000, 1'b1, 32'h0000_7777, 4'h5, 1'b0);
		probe(32'h0000_6006, 1'b1, 32'h0000_7008, 4'h8, 1'b0);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		s_basic();
		s_untaken();
		s_split();
		do_reset();
		s_kinds();
		do_reset();
		s_full();
		stop_test();
	end
endmodule
